// File: verilog/sss_pkg.sv
// Functional notes
// - Strobe is driven only in normal mode, otherwise it stays inactive high.
// - Feedback select chooses the current-sense or the voltage strobe behaviour.
// - Current sense: strobe follows the output on phase, shaped by strobe mode.
// - Mode off: strobe held inactive high permanently.
// - Mode valid: low while sense value valid, high while mux switches.
// - After-cycle mode: like valid, but high after mux change until next cycle.
// - Mid-pulse mode: low from sense pulse middle to end, blanked after switching.
// - No strobe pulse during inrush overcurrent window or PWM off phase unless the channel is at full duty.
// - Blank strobe a fixed turn-on delay plus settling time after mux or chop.
// - On PWM clock failure output a 50 % square wave of 6.5 ms period.
// - Full duty holds strobe low; trigger modes add 100 us high per overflow.
// - After an output fault no current trigger until the output is re-enabled or the select changes.
// - Voltage selection outputs 50 % square wave at PWM clock over 1024.
// - Offset chopping inverts offset sign on every strobe rising edge.
// - Chopping off by default and in fail mode; per-channel enable bit.
package sss_pkg;
  // ==========================================================
  // Register map
  localparam logic [7:0]  CTRL_OFS      = 8'h00;
  localparam logic [7:0]  STAT_OFS      = 8'h04;
  localparam int          MODE_LSB      = 0;
  localparam int          SEL_LSB       = 2;
  localparam int          CHOP_LSB      = 5;
  localparam logic [1:0]  MODE_RST      = 2'h0;
  localparam logic [2:0]  SEL_RST       = 3'h0;
  localparam logic [3:0]  CHOP_RST      = 4'h0;
  localparam int          ST_LEVEL      = 0;
  localparam int          ST_SIGN       = 1;
  localparam int          ST_FAULT      = 2;
  localparam int          ST_CLKFAIL    = 3;
  // Select codes 0..3 are channel currents
  localparam logic [2:0]  SEL_TEMP      = 3'h4;
  localparam logic [2:0]  SEL_BAT       = 3'h5;
  // ==========================================================
  // Strobe modes
  typedef enum logic [1:0] {
    SSS_OFF   = 2'h0,
    SSS_VALID = 2'h1,
    SSS_CYCLE = 2'h2,
    SSS_MID   = 2'h3
  } sss_mode_type;
  // ==========================================================
  // Timing
  localparam int CLK_NS         = 4;
  localparam int FAIL_PERIOD_NS = 6_500_000;
  localparam int FULL_PULSE_NS  = 100_000;
  localparam int TURN_ON_NS     = 1_000;
  localparam int SETTLE_NS      = 4_000;
  localparam int SLOW_DIV       = 1024;
  localparam int FAIL_HALF_CYC  = FAIL_PERIOD_NS / 2 / CLK_NS;
  localparam int FULL_PULSE_CYC = FULL_PULSE_NS / CLK_NS;
  localparam int BLANK_CYC      =
    (TURN_ON_NS + SETTLE_NS + CLK_NS - 1) / CLK_NS;
  localparam int SLOW_HALF      = SLOW_DIV / 2;
  localparam int CNT_W          = 24;
endpackage

// File: verilog/sss_tmr_if.sv
`timescale 1ns/1ps
interface sss_tmr_if #(
  parameter int W = 24
);
  logic         start;
  logic [W-1:0] len;
  logic         busy;
  modport ctl (output start, output len, input busy);
  modport tmr (input start, input len, output busy);
endinterface

// File: verilog/sss_timer.sv
`timescale 1ns/1ps
module sss_timer #(
  parameter int W = 24
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Control
  sss_tmr_if.tmr    tif
);
  logic [W-1:0] cnt_reg;

  // Restart on every start so a new event extends the window
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg <= '0;
    end else if (tif.start) begin
      cnt_reg <= tif.len;
    end else if (cnt_reg != '0) begin
      cnt_reg <= cnt_reg - 1'b1;
    end
  end

  assign tif.busy = (cnt_reg != '0);
endmodule

// File: verilog/sss_square.sv
`timescale 1ns/1ps
module sss_square #(
  parameter int W = 24
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  // Control
  input  wire logic         run_i,
  input  wire logic         tick_i,
  input  wire logic [W-1:0] half_i,
  // Wave
  output logic              wave_o
);
  logic [W-1:0] cnt_reg;
  logic         wave_reg;

  // Idle restarts the wave high so each use begins inactive
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_reg  <= '0;
      wave_reg <= 1'b1;
    end else if (!run_i) begin
      cnt_reg  <= '0;
      wave_reg <= 1'b1;
    end else if (tick_i) begin
      if (cnt_reg >= half_i - 1'b1) begin
        cnt_reg  <= '0;
        wave_reg <= ~wave_reg;
      end else begin
        cnt_reg <= cnt_reg + 1'b1;
      end
    end
  end

  assign wave_o = wave_reg;
endmodule

// File: verilog/sss_strobe_gen.sv
`timescale 1ns/1ps
module sss_strobe_gen #(
  parameter int FAIL_HALF  = sss_pkg::FAIL_HALF_CYC,
  parameter int FULL_PULSE = sss_pkg::FULL_PULSE_CYC,
  parameter int BLANK      = sss_pkg::BLANK_CYC,
  parameter int LEN_W      = 16
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       reset_n_i,
  // APB slave
  input  wire logic       psel_i,
  input  wire logic       penable_i,
  input  wire logic       pwrite_i,
  input  wire logic [7:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]     prdata_o,
  output logic            pready_o,
  output logic            pslverr_o,
  // Device state
  input  wire logic       normal_mode_i,
  input  wire logic       pwm_clk_fail_i,
  input  wire logic       pwm_clk_tick_i,
  input  wire logic       pwm_cycle_start_i,
  input  wire logic       pwm_overflow_i,
  // Per-channel output state
  input  wire logic [3:0] pwm_on_i,
  input  wire logic [3:0] full_duty_i,
  input  wire logic [3:0] inrush_overcurrent_window_i,
  input  wire logic [3:0] out_fault_i,
  input  wire logic [3:0] out_enable_i,
  // Open-drain strobe pin and chopping sign
  output logic            sense_sample_strobe_o,
  output logic            sense_sample_strobe_oe_o,
  output logic            offset_sign_o
);
  import sss_pkg::*;

  // ==========================================================
  // Reset release
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  function automatic logic rise(input logic cur, input logic prev);
    rise = cur & ~prev;
  endfunction

  // ==========================================================
  // APB registers
  sss_mode_type strobe_mode_reg;
  logic [2:0]   feedback_select_reg;
  logic [3:0]   chop_en_reg;
  logic         pready_reg;
  logic         pslverr_reg;
  logic [31:0]  prdata_reg;
  logic         strobe_reg;
  logic         chop_sign_reg;
  logic         fault_lat_reg;
  logic [31:0]  ctrl_rd;
  logic [31:0]  stat_rd;
  logic         setup;
  logic         wr_take;
  logic         known;

  assign setup   = psel_i & ~penable_i;
  assign wr_take = psel_i & penable_i & pready_reg & pwrite_i;
  assign known   = (paddr_i == CTRL_OFS) | (paddr_i == STAT_OFS);

  always_comb begin
    ctrl_rd = '0;
    ctrl_rd[MODE_LSB +: 2] = strobe_mode_reg;
    ctrl_rd[SEL_LSB +: 3]  = feedback_select_reg;
    ctrl_rd[CHOP_LSB +: 4] = chop_en_reg;
    stat_rd = '0;
    stat_rd[ST_LEVEL]   = strobe_reg;
    stat_rd[ST_SIGN]    = chop_sign_reg;
    stat_rd[ST_FAULT]   = fault_lat_reg;
    stat_rd[ST_CLKFAIL] = pwm_clk_fail_i;
  end

  // Answer is latched at setup so the access phase needs no wait
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pready_reg  <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg  <= '0;
    end else begin
      pready_reg  <= setup;
      pslverr_reg <= setup & ~known;
      if (setup && !pwrite_i && paddr_i == CTRL_OFS) begin
        prdata_reg <= ctrl_rd;
      end else if (setup && !pwrite_i && paddr_i == STAT_OFS) begin
        prdata_reg <= stat_rd;
      end else if (setup) begin
        prdata_reg <= '0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      strobe_mode_reg     <= sss_mode_type'(MODE_RST);
      feedback_select_reg <= SEL_RST;
      chop_en_reg         <= CHOP_RST;
    end else if (wr_take && paddr_i == CTRL_OFS) begin
      strobe_mode_reg     <= sss_mode_type'(pwdata_i[MODE_LSB +: 2]);
      feedback_select_reg <= pwdata_i[SEL_LSB +: 3];
      chop_en_reg         <= pwdata_i[CHOP_LSB +: 4];
    end
  end

  // ==========================================================
  // Selected channel
  logic [1:0] ch;
  logic       cur_sel;
  logic       volt_sel;
  logic       on_sel;
  logic       full_sel;
  logic       trig_mode;

  assign ch        = feedback_select_reg[1:0];
  assign cur_sel   = ~feedback_select_reg[2];
  assign volt_sel  = (feedback_select_reg == SEL_TEMP) |
                     (feedback_select_reg == SEL_BAT);
  assign on_sel    = pwm_on_i[ch];
  assign full_sel  = full_duty_i[ch];
  assign trig_mode = strobe_mode_reg[1];

  // ==========================================================
  // Event history
  logic [2:0] sel_prev_reg;
  logic       on_prev_reg;
  logic       en_prev_reg;
  logic       mux_chg;
  logic       on_rise;
  logic       chop_tgl;
  logic       strobe_next;

  assign mux_chg = (feedback_select_reg != sel_prev_reg);
  assign on_rise = rise(on_sel, on_prev_reg) & ~mux_chg;
  // Fail mode shows as the device leaving normal mode
  assign chop_tgl = rise(strobe_next, strobe_reg) & normal_mode_i &
                    cur_sel & chop_en_reg[ch];

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      sel_prev_reg <= SEL_RST;
      on_prev_reg  <= 1'b0;
      en_prev_reg  <= 1'b0;
    end else begin
      sel_prev_reg <= feedback_select_reg;
      on_prev_reg  <= on_sel;
      en_prev_reg  <= out_enable_i[ch];
    end
  end

  // Fault blocks triggers until the output is enabled again or the mux changes; set wins
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fault_lat_reg <= 1'b0;
    end else if (out_fault_i[ch]) begin
      fault_lat_reg <= 1'b1;
    end else if (mux_chg || rise(out_enable_i[ch], en_prev_reg)) begin
      fault_lat_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Blanking and full-duty pulse timers
  sss_tmr_if #(.W(CNT_W)) blank_if ();
  sss_tmr_if #(.W(CNT_W)) full_if ();

  assign blank_if.start = mux_chg | chop_tgl | on_rise;
  assign blank_if.len   = CNT_W'(BLANK);
  assign full_if.start  = pwm_overflow_i & full_sel & trig_mode;
  assign full_if.len    = CNT_W'(FULL_PULSE);

  sss_timer #(.W(CNT_W)) u_blank (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .tif     (blank_if)
  );

  sss_timer #(.W(CNT_W)) u_full (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .tif     (full_if)
  );

  // ==========================================================
  // Square waves for clock failure and voltage feedback
  logic fail_wave;
  logic slow_wave;

  sss_square #(.W(CNT_W)) u_fail_wave (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .run_i   (normal_mode_i & pwm_clk_fail_i),
    .tick_i  (1'b1),
    .half_i  (CNT_W'(FAIL_HALF)),
    .wave_o  (fail_wave)
  );

  // Counts PWM clock ticks, so it stops with a dead PWM clock
  sss_square #(.W(CNT_W)) u_slow_wave (
    .clk_i   (clk_i),
    .rst_n_i (rst_n),
    .run_i   (normal_mode_i & volt_sel),
    .tick_i  (pwm_clk_tick_i),
    .half_i  (CNT_W'(SLOW_HALF)),
    .wave_o  (slow_wave)
  );

  // ==========================================================
  // Mid-pulse tracking
  logic [LEN_W-1:0] on_cnt_reg;
  logic [LEN_W-1:0] last_len_reg;
  logic             wait_mid_reg;
  logic             wait_cycle_reg;
  logic             mid_hit;

  // The middle is taken from the previous pulse length
  assign mid_hit = on_sel & (on_cnt_reg >= (last_len_reg >> 1));

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      on_cnt_reg   <= '0;
      last_len_reg <= '0;
    end else if (on_sel) begin
      if (on_cnt_reg != '1) begin
        on_cnt_reg <= on_cnt_reg + 1'b1;
      end
    end else begin
      if (on_prev_reg) begin
        last_len_reg <= on_cnt_reg;
      end
      on_cnt_reg <= '0;
    end
  end

  // Mux change sets the waits; set wins over the clearing event
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wait_mid_reg <= 1'b0;
    end else if (mux_chg) begin
      wait_mid_reg <= 1'b1;
    end else if (mid_hit) begin
      wait_mid_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wait_cycle_reg <= 1'b0;
    end else if (mux_chg) begin
      wait_cycle_reg <= 1'b1;
    end else if (pwm_cycle_start_i) begin
      wait_cycle_reg <= 1'b0;
    end
  end

  // ==========================================================
  // Strobe selection, high is inactive
  always_comb begin
    strobe_next = 1'b1;
    if (!normal_mode_i) begin
      strobe_next = 1'b1;
    end else if (pwm_clk_fail_i) begin
      strobe_next = fail_wave;
    end else if (!cur_sel) begin
      strobe_next = volt_sel ? slow_wave : 1'b1;
    end else begin
      case (strobe_mode_reg)
        SSS_OFF: begin
          strobe_next = 1'b1;
        end
        SSS_VALID, SSS_CYCLE, SSS_MID: begin
          // A live fault blocks at once; the latch holds it afterwards
          if (fault_lat_reg || out_fault_i[ch]) begin
            strobe_next = 1'b1;
          end else if (full_sel) begin
            strobe_next = trig_mode & full_if.busy;
          end else if (!on_sel ||
                       inrush_overcurrent_window_i[ch]) begin
            strobe_next = 1'b1;
          // The timer is busy one edge after its start, so cover that cycle
          end else if (blank_if.busy || mux_chg || on_rise) begin
            strobe_next = 1'b1;
          end else if (strobe_mode_reg == SSS_VALID) begin
            strobe_next = 1'b0;
          end else if (strobe_mode_reg == SSS_CYCLE) begin
            strobe_next = wait_cycle_reg;
          end else begin
            strobe_next = ~(mid_hit & ~wait_mid_reg);
          end
        end
        default: begin
          strobe_next = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      strobe_reg <= 1'b1;
    end else begin
      strobe_reg <= strobe_next;
    end
  end

  // Sign flips with the pin's rising edge; cleared outside chopping
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      chop_sign_reg <= 1'b0;
    end else if (!normal_mode_i || !chop_en_reg[ch]) begin
      chop_sign_reg <= 1'b0;
    end else if (chop_tgl) begin
      chop_sign_reg <= ~chop_sign_reg;
    end
  end

  // ==========================================================
  // Pin drive: open drain, pulled low only when active
  logic oe_reg;
  logic pin_lvl_reg;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      oe_reg      <= 1'b0;
      pin_lvl_reg <= 1'b0;
    end else begin
      oe_reg      <= ~strobe_next;
      pin_lvl_reg <= 1'b0;
    end
  end

  assign sense_sample_strobe_o    = pin_lvl_reg;
  assign sense_sample_strobe_oe_o = oe_reg;
  assign offset_sign_o            = chop_sign_reg;
  assign prdata_o                 = prdata_reg;
  assign pready_o                 = pready_reg;
  assign pslverr_o                = pslverr_reg;
endmodule

// File: test/sss_strobe_gen_properties.sv
`timescale 1ns/1ps
// ====================
// Strobe pin checker
module sss_strobe_gen_properties
  import sss_pkg::*;
#(
  parameter int FAIL_HALF  = 20,
  parameter int FULL_PULSE = 10,
  parameter int BLANK      = 5
) (
  // Clock and reset
  input wire logic        clk_i,
  input wire logic        reset_n_i,
  // APB
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  // Device state
  input wire logic        normal_mode_i,
  input wire logic        pwm_clk_fail_i,
  input wire logic        pwm_clk_tick_i,
  input wire logic        pwm_overflow_i,
  input wire logic [3:0]  pwm_on_i,
  input wire logic [3:0]  full_duty_i,
  input wire logic [3:0]  inrush_overcurrent_window_i,
  input wire logic [3:0]  out_fault_i,
  // Outputs
  input wire logic        sense_sample_strobe_oe_o,
  input wire logic        offset_sign_o
);
  logic [1:0]  mode_q;
  logic [2:0]  sel_q;
  logic [3:0]  chop_q;
  logic        oe_q;
  logic [1:0]  reg_q;
  logic [1:0]  seen;
  logic [31:0] run;
  logic [31:0] tks;
  wire         oe  = sense_sample_strobe_oe_o;
  wire         chg = oe != oe_q;
  wire  [1:0]  ch  = sel_q[1:0];
  wire         cur = normal_mode_i && !pwm_clk_fail_i && !sel_q[2];
  // Regime: 1 clock fail, 2 voltage select, 0 anything else
  wire  [1:0]  rg  = !normal_mode_i ? 2'h0 : pwm_clk_fail_i ? 2'h1 :
                     (sel_q[2:1] == 2'h2) ? 2'h2 : 2'h0;

  // ====================
  // Shadow of the control word
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_q <= 2'h0;
      sel_q  <= 3'h0;
      chop_q <= 4'h0;
    end else if (psel_i && penable_i && pready_o && pwrite_i &&
                 paddr_i == CTRL_OFS) begin
      mode_q <= pwdata_i[1:0];
      sel_q  <= pwdata_i[4:2];
      chop_q <= pwdata_i[8:5];
    end
  end

  // ====================
  // Half-period meters; the first two edges in a regime are ignored
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      oe_q  <= 1'b0;
      reg_q <= 2'h0;
      seen  <= 2'h0;
      run   <= 32'h0;
      tks   <= 32'h0;
    end else begin
      oe_q  <= oe;
      reg_q <= rg;
      run   <= chg ? 32'h1 : run + 32'h1;
      tks   <= chg ? {31'h0, pwm_clk_tick_i} : tks + pwm_clk_tick_i;
      if (rg != reg_q)
        seen <= 2'h0;
      else if (chg && seen != 2'h2)
        seen <= seen + 2'h1;
    end
  end

  // ====================
  // Properties
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  a_not_normal: assert property (!normal_mode_i |=> !oe)
    else $error("strobe active outside normal mode");
  a_sign_off: assert property (
    (!normal_mode_i || (!sel_q[2] && !chop_q[ch])) |=> !offset_sign_o)
    else $error("offset sign set while chopping is off");
  a_mode_off: assert property (cur && mode_q == 2'h0 |=> !oe)
    else $error("strobe active in mode off");
  a_off_phase: assert property (
    cur && !pwm_on_i[ch] && !full_duty_i[ch] |=> !oe)
    else $error("strobe active in off phase");
  a_inrush_quiet: assert property (
    cur && inrush_overcurrent_window_i[ch] && !full_duty_i[ch] |=> !oe)
    else $error("strobe active in inrush window");
  a_fault_quiet: assert property (cur && out_fault_i[ch] |=> !oe)
    else $error("strobe active during output fault");
  // Five matches the shortened blanking count
  a_on_blank: assert property (
    cur && mode_q != 2'h0 && $rose(pwm_on_i[ch]) && !full_duty_i[ch]
    |=> (!oe)[*5])
    else $error("strobe not blanked after turn-on");
  a_full_pulse: assert property (
    cur && mode_q[1] && full_duty_i[ch] && pwm_overflow_i && oe &&
    !out_fault_i[ch] |-> ##[1:2] (!oe)[*8] ##[1:4] oe)
    else $error("overflow pulse length wrong at full duty");
  a_fail_wave: assert property (
    chg && rg == 2'h1 && reg_q == 2'h1 && seen == 2'h2
    |-> run == FAIL_HALF)
    else $error("clock fail half period wrong");
  a_volt_wave: assert property (
    chg && rg == 2'h2 && reg_q == 2'h2 && seen == 2'h2
    |-> tks == SLOW_HALF)
    else $error("voltage select half period wrong");
  a_chop_flip: assert property (
    $fell(oe) && $past(cur) && chop_q[ch] |-> ##[0:1] $changed(offset_sign_o))
    else $error("offset sign not inverted on strobe release");
endmodule

bind sss_strobe_gen sss_strobe_gen_properties #(
  .FAIL_HALF(FAIL_HALF),
  .FULL_PULSE(FULL_PULSE),
  .BLANK(BLANK)
) u_props (.*);

// File: test/sss_mcu_model.sv
`timescale 1ns/1ps
// ====================
// Sampling side of the strobe pin
module sss_mcu_model (
  // Clock and pin
  input  wire logic  clk_i,
  input  wire logic  strobe_i,
  input  wire logic  strobe_oe_i,
  output logic       pin_o,
  // Conversions started
  output logic [15:0] samples_o
);
  // Pull-up holds the released pin high
  assign pin_o = strobe_oe_i ? strobe_i : 1'b1;
  initial samples_o = 16'h0;
  // A high pin is a blanked value, so no conversion starts
  always @(posedge clk_i) begin
    if (pin_o === 1'b0)
      samples_o <= samples_o + 16'h1;
  end
endmodule

// File: test/sss_strobe_gen_bench.sv
`timescale 1ns/1ps
// ====================
// Strobe generator bench
module sss_strobe_gen_bench;
  import sss_pkg::*;
  localparam int FH = 20;
  logic        clk_i, reset_n_i, psel_i, penable_i, pwrite_i, err, s0, pin;
  logic        normal_mode_i, pwm_clk_fail_i, pwm_clk_tick_i;
  logic        pwm_cycle_start_i, pwm_overflow_i, pready_o, pslverr_o;
  logic        sense_sample_strobe_o, sense_sample_strobe_oe_o;
  logic        offset_sign_o;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i, prdata_o, rd, n;
  logic [3:0]  pwm_on_i, full_duty_i, inrush_overcurrent_window_i;
  logic [3:0]  out_fault_i, out_enable_i;
  logic [15:0] smp;
  int          fail_count, checked;

  sss_strobe_gen #(.FAIL_HALF(FH), .FULL_PULSE(10), .BLANK(5)) DUT (
    .clk_i, .reset_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i,
    .pwdata_i, .prdata_o, .pready_o, .pslverr_o, .normal_mode_i,
    .pwm_clk_fail_i, .pwm_clk_tick_i, .pwm_cycle_start_i,
    .pwm_overflow_i, .pwm_on_i, .full_duty_i,
    .inrush_overcurrent_window_i, .out_fault_i, .out_enable_i,
    .sense_sample_strobe_o, .sense_sample_strobe_oe_o, .offset_sign_o);

  sss_mcu_model MCU (.clk_i, .strobe_i(sense_sample_strobe_o),
    .strobe_oe_i(sense_sample_strobe_oe_o), .pin_o(pin), .samples_o(smp));

  // ====================
  // Tasks
  task automatic wt(input int c);
    repeat (c) @(posedge clk_i);
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    psel_i   <= 1'b1;
    pwrite_i <= w;
    paddr_i  <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do @(posedge clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    err = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic chk(input string s, input logic [31:0] e, g);
    checked++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask

  task automatic chkp(input string s, input logic e);
    chk(s, {31'h0, e}, {31'h0, pin});
  endtask

  // Cycles between two pin edges, after skipping to an edge
  task automatic halfp(output logic [31:0] c);
    logic v;
    v = pin;
    do @(posedge clk_i); while (pin === v);
    c = 32'h0;
    v = pin;
    do begin
      @(posedge clk_i);
      c++;
    end while (pin === v);
  endtask

  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ====================
  // Clock and watchdog
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  initial begin
    #100000;
    fail_count++;
    finish_test;
  end

  // ====================
  // Tests
  initial begin
    {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} = '0;
    {pwm_clk_fail_i, pwm_clk_tick_i, pwm_cycle_start_i} = '0;
    {pwm_overflow_i, full_duty_i, inrush_overcurrent_window_i} = '0;
    {pwm_on_i, out_fault_i, out_enable_i} = '0;
    {normal_mode_i, reset_n_i, fail_count, checked} = '0;
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    wt(3);
    apb(1'b0, CTRL_OFS, 32'h0);
    chk("ctrl reset", 32'h0, rd);
    apb(1'b1, STAT_OFS, 32'hF);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("status", 32'h1, rd);
    apb(1'b0, 8'h08, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    chkp("pin idle", 1'b1);
    $display("test reset done");
    normal_mode_i <= 1'b1;
    out_enable_i  <= 4'hF;
    pwm_on_i      <= 4'h1;
    apb(1'b1, CTRL_OFS, 32'h1);
    wt(10);
    chkp("valid", 1'b0);
    pwm_on_i <= 4'h0;
    wt(3);
    chkp("off phase", 1'b1);
    pwm_on_i <= 4'h1;
    wt(3);
    chkp("blank", 1'b1);
    inrush_overcurrent_window_i <= 4'h1;
    wt(10);
    chkp("inrush", 1'b1);
    inrush_overcurrent_window_i <= 4'h0;
    normal_mode_i <= 1'b0;
    wt(3);
    chkp("not normal", 1'b1);
    normal_mode_i <= 1'b1;
    apb(1'b1, CTRL_OFS, 32'h0);
    wt(10);
    chkp("mode off", 1'b1);
    $display("test valid done");
    pwm_on_i <= 4'h2;
    apb(1'b1, CTRL_OFS, 32'h6);
    wt(10);
    chkp("wait cycle", 1'b1);
    pwm_cycle_start_i <= 1'b1;
    wt(1);
    pwm_cycle_start_i <= 1'b0;
    wt(3);
    chkp("after cycle", 1'b0);
    apb(1'b1, CTRL_OFS, 32'h7);
    for (int i = 0; i < 3; i++) begin
      pwm_on_i <= 4'h0;
      wt(10);
      pwm_on_i <= 4'h2;
      wt(12);
      if (i == 2)
        chkp("before mid", 1'b1);
      wt(14);
      if (i == 2)
        chkp("after mid", 1'b0);
    end
    full_duty_i <= 4'h2;
    apb(1'b1, CTRL_OFS, 32'h6);
    wt(5);
    chkp("full duty", 1'b0);
    pwm_overflow_i <= 1'b1;
    wt(1);
    pwm_overflow_i <= 1'b0;
    wt(4);
    chkp("overflow pulse", 1'b1);
    wt(10);
    chkp("pulse end", 1'b0);
    out_fault_i <= 4'h2;
    wt(3);
    out_fault_i <= 4'h0;
    wt(3);
    chkp("fault latch", 1'b1);
    out_enable_i <= 4'hD;
    wt(2);
    out_enable_i <= 4'hF;
    wt(4);
    chkp("re-enabled", 1'b0);
    full_duty_i <= 4'h0;
    $display("test trigger done");
    apb(1'b1, CTRL_OFS, 32'h45);
    pwm_on_i <= 4'h0;
    wt(10);
    apb(1'b0, STAT_OFS, 32'h0);
    s0 = rd[1];
    pwm_on_i <= 4'h2;
    wt(20);
    pwm_on_i <= 4'h0;
    wt(10);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("sign flip", {31'h0, ~s0}, {31'h0, rd[1]});
    normal_mode_i <= 1'b0;
    wt(3);
    apb(1'b0, STAT_OFS, 32'h0);
    chk("sign fail mode", 32'h1, rd);
    normal_mode_i <= 1'b1;
    $display("test chop done");
    pwm_clk_fail_i <= 1'b1;
    halfp(n);
    halfp(n);
    chk("fail half", FH, n);
    pwm_clk_fail_i <= 1'b0;
    pwm_clk_tick_i <= 1'b1;
    apb(1'b1, CTRL_OFS, 32'h11);
    halfp(n);
    halfp(n);
    chk("slow half", SLOW_HALF, n);
    pwm_clk_tick_i <= 1'b0;
    chk("samples", 32'h1, {31'h0, smp != 16'h0});
    $display("test waves done");
    finish_test;
  end
endmodule
